// ---- prig_pkg.sv ----
// Constants for the position reference gating and gear block.
// Assumes a 50 MHz ref_clk and a byte-addressed register port.
package prig_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_NUM   = 8'h04;
    localparam logic [7:0] OFS_DEN   = 8'h08;
    localparam logic [7:0] OFS_PPR   = 8'h0C;
    localparam logic [7:0] OFS_EBITS = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    localparam logic [7:0] OFS_MPOS  = 8'h18;
    localparam logic [7:0] OFS_STAT  = 8'h1C;
    localparam logic [7:0] OFS_MASK  = 8'h20;
    // Control fields
    localparam int CTRL_POS_BIT = 0;
    localparam int CTRL_SRC_LSB = 1;
    localparam logic [1:0] SRC_PULSE = 2'h0;
    // Status bits
    localparam int ST_FAULT = 0;
    localparam int ST_DROP  = 1;
    localparam int ST_EARLY = 2;
    // Reset values
    localparam logic [2:0]  RST_CTRL  = 3'h0;
    localparam logic [31:0] RST_NUM   = 32'h0080_0000;
    localparam logic [31:0] RST_DEN   = 32'h0000_2710;
    localparam logic [31:0] RST_PPR   = 32'h0;
    localparam logic [4:0]  RST_EBITS = 5'h17;
    localparam logic [2:0]  RST_MASK  = 3'h0;
    // Gear ratio limit factors
    localparam logic [79:0] LIM_DEN    = 80'h2710;
    localparam logic [79:0] LIM_LO_INV = 80'h3E8;
    localparam logic [79:0] LIM_HI     = 80'hFA0;
    // Release guard time
    localparam int CLK_MHZ     = 50;
    localparam int T_RELEASE_US = 500;
    localparam int REL_CYC     = T_RELEASE_US * CLK_MHZ;
endpackage

// ---- prig_top.sv ----
// Position reference gating, input counter and electronic gear.
// Block pins and pulse pins are asynchronous; int_ref_* is on ref_clk.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// RULE1: All-block input zeroes every position reference
// RULE2: All-block locks motor; mode switching stays possible
// RULE3: Counter keeps counting during all-block
// RULE4: References counted while blocked are discarded
// RULE5: Pulse-block input zeroes pulse-terminal references
// RULE6: Pulse-block leaves other sources working
// RULE7: Blocked pulses counted but never executed
// RULE8: Other sources counted and executed during pulse-block
// RULE9: Pulse-block acts only with pulse source selected
// RULE10: Controller waits half millisecond after release
// RULE11: Fault when gear ratio outside limits
// RULE12: References scaled by B over A
// RULE13: Encoder resolution is two to encoder bits
// RULE14: Nonzero pulses-per-rev overrides gear ratio
// RULE15: Block inputs synchronised before gating
module prig_top #(
    parameter int RELEASE_CYCLES = prig_pkg::REL_CYC
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // Pins
    input  wire logic               all_ref_block_input,
    input  wire logic               pulse_ref_block_input,
    input  wire logic               pulse_in,
    input  wire logic               pulse_dir,
    // Internal reference source
    input  wire logic               int_ref_valid,
    input  wire logic signed [15:0] int_ref_delta,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // Motor reference and status
    output logic                    motor_step,
    output logic                    motor_dir,
    output logic signed [31:0]      motor_pos,
    output logic                    gear_ratio_limit_fault,
    output logic                    irq
);
    logic [3:0]         sync1_q;
    logic [3:0]         sync2_q;
    logic               pin3_q;
    logic [2:0]         ctrl_q;
    logic [31:0]        num_q;
    logic [31:0]        den_q;
    logic [31:0]        pulses_per_rev_setting;
    logic [4:0]         ebits_q;
    logic [2:0]         mask_q;
    logic [2:0]         stat_q;
    logic [2:0]         stat_set;
    logic signed [31:0] input_reference_counter;
    logic signed [63:0] rem_q;
    logic signed [31:0] mpos_q;
    logic               step_q;
    logic               dir_q;
    logic               fault_q;
    logic [15:0]        rel_q;
    logic [1:0]         pin_blk_prev_q;
    logic [31:0]        rdata_q;
    logic               mode_pos;
    logic [1:0]         position_ref_source_select;
    logic               blk_all;
    logic               pulse_ref_block;
    logic               pulse_ev;
    logic               int_ev;
    logic               ref_ev;
    logic signed [15:0] ref_delta;
    logic               exec;
    logic               dropped;
    logic [31:0]        eff_b;
    logic [31:0]        eff_a;
    logic [79:0]        ra80;
    logic [79:0]        b80;
    logic               fault_w;
    logic signed [63:0] a_s;
    logic signed [63:0] add_w;
    logic               step_up;
    logic               step_dn;
    logic               early;

    // Two-stage synchronisers for all pins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            pin3_q  <= 1'b0;
        end else begin
            sync1_q <= {pulse_dir, pulse_in, pulse_ref_block_input,
                        all_ref_block_input};  // RULE15
            sync2_q <= sync1_q;  // RULE15
            pin3_q  <= sync2_q[2];
        end
    end

    // Reference gating
    assign mode_pos = ctrl_q[prig_pkg::CTRL_POS_BIT];
    assign position_ref_source_select = ctrl_q[prig_pkg::CTRL_SRC_LSB +: 2];
    assign blk_all  = sync2_q[0] & mode_pos;  // RULE1
    assign pulse_ref_block = sync2_q[1] & mode_pos &
                      (position_ref_source_select == prig_pkg::SRC_PULSE);  // RULE9
    assign pulse_ev = sync2_q[2] & ~pin3_q & mode_pos &
                      (position_ref_source_select == prig_pkg::SRC_PULSE);
    assign int_ev   = int_ref_valid & mode_pos &
                      (position_ref_source_select != prig_pkg::SRC_PULSE);  // RULE6
    assign ref_ev   = pulse_ev | int_ev;
    assign ref_delta = pulse_ev ? (sync2_q[3] ? -16'sh1 : 16'sh1) : int_ref_delta;
    assign exec     = ref_ev & ~blk_all & ~(pulse_ev & pulse_ref_block) & ~fault_q;  // RULE1 RULE5 RULE8
    assign dropped  = ref_ev & ~exec;  // RULE4 RULE7

    // Effective gear ratio and its limits
    assign eff_b = (pulses_per_rev_setting != 32'h0) ? (32'h1 << ebits_q) : num_q;  // RULE13 RULE14
    assign eff_a = (pulses_per_rev_setting != 32'h0) ? pulses_per_rev_setting : den_q;  // RULE14
    assign ra80  = (80'h1 << ebits_q) * {48'h0, eff_a};  // RULE13
    assign b80   = {48'h0, eff_b};
    assign fault_w = (eff_a == 32'h0) | (eff_b == 32'h0) |
                     (ra80 > b80 * prig_pkg::LIM_DEN * prig_pkg::LIM_LO_INV) |
                     (b80 * prig_pkg::LIM_DEN > ra80 * prig_pkg::LIM_HI);  // RULE11

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_w;  // RULE11
        end
    end

    // Input reference counter counts gated and open references alike
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_reference_counter <= 32'sh0;
        end else if (ref_ev) begin
            input_reference_counter <= input_reference_counter + 32'(ref_delta);  // RULE3 RULE7 RULE8
        end
    end

    // Gear: remainder accumulates delta*B, one encoder unit per A
    assign a_s     = signed'({32'h0, eff_a});
    assign add_w   = exec ? 64'(ref_delta * signed'({1'b0, eff_b})) : 64'sh0;  // RULE12
    assign step_up = ~blk_all & ~fault_q & (rem_q >= a_s);  // RULE2
    assign step_dn = ~blk_all & ~fault_q & (rem_q < 64'sh0);  // RULE2

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rem_q  <= 64'sh0;
            mpos_q <= 32'sh0;
            step_q <= 1'b0;
            dir_q  <= 1'b0;
        end else begin
            rem_q  <= rem_q + add_w - (step_up ? a_s : 64'sh0)
                      + (step_dn ? a_s : 64'sh0);  // RULE12
            step_q <= step_up | step_dn;
            if (step_up) begin
                mpos_q <= mpos_q + 32'sh1;
                dir_q  <= 1'b0;
            end else if (step_dn) begin
                mpos_q <= mpos_q - 32'sh1;
                dir_q  <= 1'b1;
            end
        end
    end

    // Guard window after the last active block input is released
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rel_q <= 16'h0;
        end else if (sync2_q[1:0] == 2'h0 && pin_blk_prev_q != 2'h0) begin
            rel_q <= 16'(RELEASE_CYCLES);  // RULE10
        end else if (rel_q != 16'h0) begin
            rel_q <= rel_q - 16'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_blk_prev_q <= 2'h0;
        end else begin
            pin_blk_prev_q <= sync2_q[1:0];
        end
    end

    assign early = int_ev & (rel_q != 16'h0);  // RULE10

    // Configuration registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q  <= prig_pkg::RST_CTRL;
            num_q   <= prig_pkg::RST_NUM;
            den_q   <= prig_pkg::RST_DEN;
            pulses_per_rev_setting <= prig_pkg::RST_PPR;
            ebits_q <= prig_pkg::RST_EBITS;
            mask_q  <= prig_pkg::RST_MASK;
        end else if (reg_wr) begin
            case (reg_addr)
                prig_pkg::OFS_CTRL:  ctrl_q  <= reg_wdata[2:0];
                prig_pkg::OFS_NUM:   num_q   <= reg_wdata;
                prig_pkg::OFS_DEN:   den_q   <= reg_wdata;
                prig_pkg::OFS_PPR:   pulses_per_rev_setting <= reg_wdata;
                prig_pkg::OFS_EBITS: ebits_q <= reg_wdata[4:0];
                prig_pkg::OFS_MASK:  mask_q  <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by read, set wins
    assign stat_set = {early, dropped, fault_w & ~fault_q};
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= 3'h0;
        end else if (reg_rd && reg_addr == prig_pkg::OFS_STAT) begin
            stat_q <= stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                prig_pkg::OFS_CTRL:  rdata_q <= {29'h0, ctrl_q};
                prig_pkg::OFS_NUM:   rdata_q <= num_q;
                prig_pkg::OFS_DEN:   rdata_q <= den_q;
                prig_pkg::OFS_PPR:   rdata_q <= pulses_per_rev_setting;
                prig_pkg::OFS_EBITS: rdata_q <= {27'h0, ebits_q};
                prig_pkg::OFS_COUNT: rdata_q <= input_reference_counter;
                prig_pkg::OFS_MPOS:  rdata_q <= mpos_q;
                prig_pkg::OFS_STAT:  rdata_q <= {29'h0, stat_q};
                prig_pkg::OFS_MASK:  rdata_q <= {29'h0, mask_q};
                default:             rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    assign reg_rdata  = rdata_q;
    assign motor_step = step_q;
    assign motor_dir  = dir_q;
    assign motor_pos  = mpos_q;
    assign gear_ratio_limit_fault = fault_q;
    assign irq = |(stat_q & mask_q);

    // Checks
    property p_all_freeze;
        @(posedge ref_clk) disable iff (sys_rst)
        blk_all |=> rem_q == $past(rem_q);
    endproperty
    a_all_freeze: assert property (p_all_freeze) else $error("remainder moved under block");  // RULE1

    property p_locked;
        @(posedge ref_clk) disable iff (sys_rst)
        blk_all |=> !motor_step && motor_pos == $past(motor_pos);
    endproperty
    a_locked: assert property (p_locked) else $error("motor moved while locked");  // RULE2

    property p_count;
        @(posedge ref_clk) disable iff (sys_rst)
        ref_ev |=> input_reference_counter ==
                   $past(input_reference_counter) + 32'($past(ref_delta));
    endproperty
    a_count: assert property (p_count) else $error("counter missed a reference");  // RULE3

    property p_drop_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        dropped |=> stat_q[prig_pkg::ST_DROP];
    endproperty
    a_drop_flag: assert property (p_drop_flag) else $error("drop not flagged");  // RULE4

    property p_pulse_blk;
        @(posedge ref_clk) disable iff (sys_rst)
        (pulse_ev && pulse_ref_block) |=> rem_q == $past(rem_q) - ($past(step_up) ?
            $past(a_s) : 64'sh0) + ($past(step_dn) ? $past(a_s) : 64'sh0);
    endproperty
    a_pulse_blk: assert property (p_pulse_blk) else $error("blocked pulse executed");  // RULE5

    property p_other_src;
        @(posedge ref_clk) disable iff (sys_rst)
        (int_ev && !blk_all && !fault_q) |-> exec;
    endproperty
    a_other_src: assert property (p_other_src) else $error("other source dropped");  // RULE8

    property p_src_only;
        @(posedge ref_clk) disable iff (sys_rst)
        (position_ref_source_select != prig_pkg::SRC_PULSE) |-> !pulse_ref_block;
    endproperty
    a_src_only: assert property (p_src_only) else $error("pulse block with other source");  // RULE9

    property p_fault;
        @(posedge ref_clk) disable iff (sys_rst)
        (eff_a == 32'h0) |=> gear_ratio_limit_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("zero ratio not faulted");  // RULE11

    property p_step;
        @(posedge ref_clk) disable iff (sys_rst)
        step_up |=> motor_step && !motor_dir && motor_pos == $past(motor_pos) + 32'sh1;
    endproperty
    a_step: assert property (p_step) else $error("step up wrong");  // RULE12

    property p_ppr;
        @(posedge ref_clk) disable iff (sys_rst)
        (pulses_per_rev_setting != 32'h0) |-> eff_b == (32'h1 << ebits_q);
    endproperty
    a_ppr: assert property (p_ppr) else $error("ppr override wrong");  // RULE14

    property p_sync;
        @(posedge ref_clk) disable iff (sys_rst)
        blk_all |-> $past(all_ref_block_input, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("block not synchronised");  // RULE15
endmodule

// ---- prig_host.sv ----
// Host controller model: pulse train and internal reference strobes.
// Assumes the bench owns ref_clk and both block pins.
`timescale 1ns/1ps
module prig_host #(
    parameter int GUARD = 26
) (
    // Clock and block pins seen
    input  wire logic          ref_clk,
    input  wire logic          all_ref_block_input,
    input  wire logic          pulse_ref_block_input,
    // References towards the drive
    output logic               pulse_in,
    output logic               pulse_dir,
    output logic               int_ref_valid,
    output logic signed [15:0] int_ref_delta
);
    int   quiet = GUARD;
    logic blocked;
    assign blocked = all_ref_block_input | pulse_ref_block_input;
    initial begin
        pulse_in = 1'b0;
        pulse_dir = 1'b0;
        int_ref_valid = 1'b0;
        int_ref_delta = 16'h0;
    end
    // Cycles since the last block pin fell
    always @(posedge ref_clk) begin
        if (blocked) begin
            quiet <= 0;
        end else if (quiet < GUARD) begin
            quiet <= quiet + 1;
        end
    end
    // Internal reference; early skips the wait after a release
    task automatic send_int(input logic signed [15:0] dv, input bit early);
        for (int n = 0; n < GUARD && !early && !blocked && quiet < GUARD; n++) begin
            @(posedge ref_clk);
        end
        @(posedge ref_clk);
        int_ref_valid <= 1'b1;
        int_ref_delta <= dv;
        @(posedge ref_clk);
        int_ref_valid <= 1'b0;
        int_ref_delta <= ~dv;
    endtask
    // Pulses with the direction set ahead and held
    task automatic send_pulses(input int n, input logic dn);
        repeat (n) begin
            @(posedge ref_clk);
            pulse_dir <= dn;
            @(posedge ref_clk);
            pulse_in <= 1'b1;
            repeat (2) @(posedge ref_clk);
            pulse_in <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
endmodule

// ---- prig_top_tb.sv ----
// Self-checking bench for prig_top driven by the host model.
// Assumes prig_pkg, prig_top and prig_host are compiled first.
`timescale 1ns/1ps
module prig_top_tb;
    localparam int REL = 20;
    logic               ref_clk, sys_rst, all_ref_block_input, pulse_ref_block_input;
    logic               pulse_in, pulse_dir, int_ref_valid, reg_wr, reg_rd;
    logic               motor_step, motor_dir, gear_ratio_limit_fault, irq;
    logic signed [15:0] int_ref_delta;
    logic signed [31:0] motor_pos;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata, reg_rdata, rv;
    int                 failures, comparisons, d;
    int                 steps = 0;
    longint             exp_pos, exp_cnt, rem, gb, ga;
    logic [7:0]         ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
    logic [31:0]        re [9] = '{32'h0, prig_pkg::RST_NUM, prig_pkg::RST_DEN, 32'h0, 32'h17,
                                   32'h0, 32'h0, 32'h0, 32'h0};
    int                 fb [5] = '{6, 7, 1, 1, 0};
    int                 fa [5] = '{1, 1, 625000, 625001, 1};
    prig_top #(.RELEASE_CYCLES(REL)) dut_u (
        .ref_clk, .sys_rst, .all_ref_block_input, .pulse_ref_block_input, .pulse_in,
        .pulse_dir, .int_ref_valid, .int_ref_delta, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .motor_step, .motor_dir, .motor_pos,
        .gear_ratio_limit_fault, .irq
    );
    prig_host #(.GUARD(REL + 6)) host_u (
        .ref_clk, .all_ref_block_input, .pulse_ref_block_input, .pulse_in, .pulse_dir,
        .int_ref_valid, .int_ref_delta
    );
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Net step count seen on the step and direction outputs
    always @(negedge ref_clk) begin
        if (motor_step === 1'b1) begin
            steps <= steps + (motor_dir ? -1 : 1);
        end
    end
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    // Counter and gear remainder as the block should track them
    function automatic void expect_ref(input int dd, input bit run);
        exp_cnt += dd;
        if (run) begin
            rem += dd * gb;
            while (rem >= ga) begin
                exp_pos++;
                rem -= ga;
            end
            while (rem < 0) begin
                exp_pos--;
                rem += ga;
            end
        end
    endfunction
    // Gear ratio limit check with resolution two to the encoder bits
    function automatic bit exp_fault(input longint b, input longint a, input int bits);
        longint r;
        r = longint'(1) << bits;
        return (a == 0) || (b == 0) || (r * a > b * 10000 * 1000) ||
               (b * 10000 > 4000 * r * a);
    endfunction
    task automatic settle();
        int n;
        for (n = 0; n < 600; n++) begin
            if (motor_pos === 32'(exp_pos)) break;
            tick();
        end
        if (n == 600) begin
            failures++;
            give_verdict();
        end
        repeat (3) tick();
    endtask
    task automatic set_gear(input longint b, input longint a);
        wr(prig_pkg::OFS_NUM, 32'(b));
        wr(prig_pkg::OFS_DEN, 32'(a));
        gb = b;
        ga = a;
        // The block steps off any remainder the new denominator leaves
        if (!exp_fault(b, a, 4)) begin
            while (rem >= ga) begin
                exp_pos++;
                rem -= ga;
            end
        end
        repeat (3) tick();
    endtask
    initial begin
        sys_rst = 1'b1;
        {all_ref_block_input, pulse_ref_block_input, reg_wr, reg_rd} = 4'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        {failures, comparisons} = 64'h0;
        {exp_pos, exp_cnt, rem} = 192'h0;
        rv = $urandom(47718);
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(ra[i]);
            chk(rv, re[i]);
        end
        chk(32'(gear_ratio_limit_fault), 32'h0);
        $display("Reset values done");
        wr(prig_pkg::OFS_EBITS, 32'h4);
        wr(prig_pkg::OFS_MASK, 32'h1);
        wr(prig_pkg::OFS_CTRL, 32'h3);
        for (int r = 0; r < 8; r++) begin
            set_gear(r == 0 ? 1 : 1 + $urandom_range(5), r == 0 ? 4 : 1 + $urandom_range(3));
            d = int'($urandom_range(40)) - 20;
            host_u.send_int(16'(d), 1'b0);
            expect_ref(d, 1'b1);
            settle();
            chk(motor_pos, 32'(exp_pos));
            if (d < -4) chk(32'(motor_dir), 32'h1);
        end
        rd(prig_pkg::OFS_COUNT);
        chk(rv, 32'(exp_cnt));
        $display("Gear scaling done");
        rd(prig_pkg::OFS_STAT);
        for (int i = 0; i < 5; i++) begin
            set_gear(fb[i], fa[i]);
            chk(32'(gear_ratio_limit_fault), 32'(exp_fault(fb[i], fa[i], 4)));
            if (i == 1 || i == 3) begin
                chk(32'(irq), 32'h1);
                rd(prig_pkg::OFS_STAT);
                chk(rv & 32'h1, 32'h1);
                tick();
                chk(32'(irq), 32'h0);
            end
        end
        host_u.send_int(16'sd5, 1'b0);
        expect_ref(5, 1'b0);
        repeat (8) tick();
        chk(motor_pos, 32'(exp_pos));
        $display("Ratio limits done");
        set_gear(3, 2);
        all_ref_block_input <= 1'b1;
        repeat (4) tick();
        for (int k = 0; k < 3; k++) begin
            d = 1 + int'($urandom_range(8));
            host_u.send_int(16'(d), 1'b0);
            expect_ref(d, 1'b0);
        end
        repeat (6) tick();
        chk(motor_pos, 32'(exp_pos));
        chk(32'(irq), 32'h0);
        wr(prig_pkg::OFS_MASK, 32'h2);
        repeat (2) tick();
        chk(32'(irq), 32'h1);
        rd(prig_pkg::OFS_STAT);
        chk(rv & 32'h2, 32'h2);
        rd(prig_pkg::OFS_COUNT);
        chk(rv, 32'(exp_cnt));
        all_ref_block_input <= 1'b0;
        repeat (REL + 10) tick();
        chk(motor_pos, 32'(exp_pos));
        $display("All-reference block done");
        pulse_ref_block_input <= 1'b1;
        repeat (4) tick();
        d = -1 - int'($urandom_range(8));
        host_u.send_int(16'(d), 1'b0);
        expect_ref(d, 1'b1);
        settle();
        chk(motor_pos, 32'(exp_pos));
        pulse_ref_block_input <= 1'b0;
        wr(prig_pkg::OFS_MASK, 32'h4);
        host_u.send_int(16'sd3, 1'b1);
        expect_ref(3, 1'b1);
        settle();
        chk(motor_pos, 32'(exp_pos));
        chk(32'(irq), 32'h1);
        rd(prig_pkg::OFS_STAT);
        chk(rv & 32'h4, 32'h4);
        $display("Internal source under pulse block done");
        wr(prig_pkg::OFS_CTRL, 32'h1);
        host_u.send_pulses(3, 1'b0);
        repeat (3) expect_ref(1, 1'b1);
        settle();
        chk(motor_pos, 32'(exp_pos));
        pulse_ref_block_input <= 1'b1;
        repeat (4) tick();
        host_u.send_pulses(2, 1'b1);
        repeat (2) expect_ref(-1, 1'b0);
        repeat (6) tick();
        chk(motor_pos, 32'(exp_pos));
        rd(prig_pkg::OFS_COUNT);
        chk(rv, 32'(exp_cnt));
        pulse_ref_block_input <= 1'b0;
        repeat (REL + 10) tick();
        chk(motor_pos, 32'(exp_pos));
        $display("Pulse block done");
        wr(prig_pkg::OFS_PPR, 32'h8);
        wr(prig_pkg::OFS_CTRL, 32'h3);
        wr(prig_pkg::OFS_NUM, 32'h7);
        wr(prig_pkg::OFS_DEN, 32'h1);
        gb = 16;
        ga = 8;
        repeat (3) tick();
        chk(32'(gear_ratio_limit_fault), 32'h0);
        host_u.send_int(16'sd5, 1'b0);
        expect_ref(5, 1'b1);
        settle();
        chk(motor_pos, 32'(exp_pos));
        $display("Pulses per revolution done");
        chk(32'(steps), 32'(exp_pos));
        give_verdict();
    end
endmodule
